// [mgmt_csr_pkg.sv]
// Shared register map, field layout and timing constants
package mgmt_csr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // Word offsets of the PHY region registers
  localparam logic [15:0] OFS_REVISION = 16'h0300;
  localparam logic [15:0] OFS_SCRATCH = 16'h0301;
  localparam logic [15:0] OFS_NAME0 = 16'h0302;
  localparam logic [15:0] OFS_NAME1 = 16'h0303;
  localparam logic [15:0] OFS_NAME2 = 16'h0304;
  localparam logic [15:0] OFS_SETUP = 16'h0310;
  // Region bases, each 256 words; decoded on the upper byte
  localparam logic [7:0] REGION_PHY = 8'h03;
  localparam logic [7:0] REGION_TXMAC = 8'h04;
  localparam logic [7:0] REGION_RXMAC = 8'h05;
  // Reset values
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] SETUP_MASK = 32'h0000_0037;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Identity words: arbitrary neutral values
  localparam logic [31:0] REVISION_VAL = 32'h0000_0001;
  localparam logic [31:0] NAME0_VAL = 32'h0000_4142;
  localparam logic [31:0] NAME1_VAL = 32'h0000_4344;
  localparam logic [31:0] NAME2_VAL = 32'h0045_4647;
  // Read latency of the device side, in cycles of wait
  localparam int RD_WAIT_CYC = 1;
  // Controller-side registers (own port)
  localparam logic [3:0] CTL_CMD = 4'h0;
  localparam logic [3:0] CTL_ADDR = 4'h1;
  localparam logic [3:0] CTL_WDATA = 4'h2;
  localparam logic [3:0] CTL_RDATA = 4'h3;
  localparam logic [3:0] CTL_STATUS = 4'h4;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  // Hard reset hold, in cycles
  localparam int RST_HOLD_CYC = 10;
endpackage : mgmt_csr_pkg

// [mgmt_if.sv]
// Management port joining the device and its bus master
`timescale 1ns/10ps
interface mgmt_if;
  logic [15:0] addr;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic readdata_valid;
  logic waitrequest;
  logic legacy_rst;
  modport device (
    input addr, read, write, writedata, legacy_rst,
    output readdata, readdata_valid, waitrequest
  );
  modport master (
    output addr, read, write, writedata, legacy_rst,
    input readdata, readdata_valid, waitrequest
  );
endinterface : mgmt_if

// [rst_sync.sv]
// Asynchronous-assert, synchronous-release reset synchroniser
`timescale 1ns/10ps
module rst_sync (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  output logic srst_n_o
);
  logic meta_q;
  // Two stages; only the second is read outside
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= 1'b0;
      srst_n_o <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      srst_n_o <= meta_q;
    end
  end
endmodule : rst_sync

// [mgmt_csr_device.sv]
// Device end: register bank, hard reset handling and link status
`timescale 1ns/10ps
module mgmt_csr_device #(
  parameter int LANES = 2,
  parameter bit FAULT_GEN_EN = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic tx_rst_n_i,
  input wire logic rx_rst_n_i,
  input wire logic csr_rst_n_i,
  mgmt_if.device bus,
  input wire logic [LANES-1:0] lane_tx_stable_i,
  input wire logic [LANES-1:0] lane_block_lock_i,
  input wire logic [LANES-1:0] lane_marker_found_i,
  input wire logic [LANES-1:0] lane_deskewed_i,
  input wire logic mac_local_fault_i,
  input wire logic mac_remote_fault_i,
  output logic tx_lanes_stable_o,
  output logic rx_block_lock_o,
  output logic receive_marker_found_o,
  output logic rx_pcs_ready_o,
  output logic local_fault_o,
  output logic remote_fault_o,
  output logic [31:0] setup_ctrl_o
);
  import mgmt_csr_pkg::*;

  logic tx_arst_n;
  logic rx_arst_n;
  logic csr_srst_n;
  logic tx_srst_n;
  logic rx_srst_n;
  logic [31:0] scratch_q;
  logic [31:0] setup_q;
  logic [31:0] rd_data_d;
  logic rd_pend_q;
  logic [15:0] rd_addr_q;
  logic [LANES-1:0] tx_s1_q, tx_s2_q, bl_s1_q, bl_s2_q;
  logic [LANES-1:0] am_s1_q, am_s2_q, dk_s1_q, dk_s2_q;
  logic [1:0] flt_s1_q, flt_s2_q;

  // Path resets combine with the global one; legacy input unused
  assign tx_arst_n = tx_rst_n_i & csr_rst_n_i & ~sys_rst_i;
  assign rx_arst_n = rx_rst_n_i & csr_rst_n_i & ~sys_rst_i;

  // Hard resets are synchronised; pulse must last hold
  rst_sync u_csr_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(csr_rst_n_i & ~sys_rst_i),
    .srst_n_o(csr_srst_n)
  );
  rst_sync u_tx_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(tx_arst_n),
    .srst_n_o(tx_srst_n)
  );
  rst_sync u_rx_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(rx_arst_n),
    .srst_n_o(rx_srst_n)
  );

  // PHY registers: only global reset clears them
  always_ff @(posedge ref_clk_i or negedge csr_srst_n)
  begin
    if (!csr_srst_n)
    begin
      scratch_q <= SCRATCH_RST;
      setup_q <= SETUP_RST;
    end
    else if (bus.write && !rd_pend_q)
    begin
      // Writes complete at once, no wait state
      if (bus.addr == OFS_SCRATCH)
        scratch_q <= bus.writedata;
      else if (bus.addr == OFS_SETUP)
        setup_q <= bus.writedata & SETUP_MASK;
    end
  end

  // Read handshake: one wait cycle then data with valid
  always_ff @(posedge ref_clk_i or negedge csr_srst_n)
  begin
    if (!csr_srst_n)
    begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 16'h0000;
    end
    else
    begin
      rd_pend_q <= bus.read && !rd_pend_q;
      rd_addr_q <= bus.addr;
    end
  end

  // Read decode over the three regions; MAC space reads zero
  always_comb
  begin
    rd_data_d = UNMAPPED_DATA;
    case (rd_addr_q[15:8])
      REGION_PHY:
      begin
        case (rd_addr_q)
          OFS_REVISION: rd_data_d = REVISION_VAL;
          OFS_SCRATCH: rd_data_d = scratch_q;
          OFS_NAME0: rd_data_d = NAME0_VAL;
          OFS_NAME1: rd_data_d = NAME1_VAL;
          OFS_NAME2: rd_data_d = NAME2_VAL;
          OFS_SETUP: rd_data_d = setup_q;
          default: rd_data_d = UNMAPPED_DATA;
        endcase
      end
      REGION_TXMAC: rd_data_d = UNMAPPED_DATA;
      REGION_RXMAC: rd_data_d = UNMAPPED_DATA;
      default: rd_data_d = UNMAPPED_DATA;
    endcase
  end

  // Answer registers; silent while global reset is in force
  always_ff @(posedge ref_clk_i or negedge csr_srst_n)
  begin
    if (!csr_srst_n)
    begin
      bus.readdata <= 32'h0000_0000;
      bus.readdata_valid <= 1'b0;
    end
    else
    begin
      bus.readdata_valid <= rd_pend_q;
      if (rd_pend_q)
        bus.readdata <= rd_data_d;
    end
  end

  // Wait: high in the read's first cycle, and through global reset
  // Independent of link and path resets, so port keeps answering
  always_comb
  begin
    bus.waitrequest = !csr_srst_n || (bus.read && !rd_pend_q);
  end

  assign setup_ctrl_o = setup_q;

  // Status inputs are asynchronous: two flops before use
  always_ff @(posedge ref_clk_i or negedge tx_srst_n)
  begin
    if (!tx_srst_n)
    begin
      tx_s1_q <= '0;
      tx_s2_q <= '0;
      tx_lanes_stable_o <= 1'b0;
    end
    else
    begin
      tx_s1_q <= lane_tx_stable_i;
      tx_s2_q <= tx_s1_q;
      tx_lanes_stable_o <= &tx_s2_q;
    end
  end

  // Receive lock chain; reset by RX or global reset
  always_ff @(posedge ref_clk_i or negedge rx_srst_n)
  begin
    if (!rx_srst_n)
    begin
      bl_s1_q <= '0;
      bl_s2_q <= '0;
      am_s1_q <= '0;
      am_s2_q <= '0;
      dk_s1_q <= '0;
      dk_s2_q <= '0;
      rx_block_lock_o <= 1'b0;
      receive_marker_found_o <= 1'b0;
      rx_pcs_ready_o <= 1'b0;
    end
    else
    begin
      bl_s1_q <= lane_block_lock_i;
      bl_s2_q <= bl_s1_q;
      am_s1_q <= lane_marker_found_i;
      am_s2_q <= am_s1_q;
      dk_s1_q <= lane_deskewed_i;
      dk_s2_q <= dk_s1_q;
      rx_block_lock_o <= &bl_s2_q;
      receive_marker_found_o <= &am_s2_q;
      // Ready needs lock, markers and deskew on every lane
      rx_pcs_ready_o <= &dk_s2_q & &am_s2_q & &bl_s2_q;
    end
  end

  // Fault flags, present only with fault generation enabled
  always_ff @(posedge ref_clk_i or negedge rx_srst_n)
  begin
    if (!rx_srst_n)
    begin
      flt_s1_q <= 2'h0;
      flt_s2_q <= 2'h0;
      local_fault_o <= 1'b0;
      remote_fault_o <= 1'b0;
    end
    else
    begin
      flt_s1_q <= {mac_remote_fault_i, mac_local_fault_i};
      flt_s2_q <= flt_s1_q;
      local_fault_o <= FAULT_GEN_EN & flt_s2_q[0];
      remote_fault_o <= FAULT_GEN_EN & flt_s2_q[1];
    end
  end
endmodule : mgmt_csr_device

// [mgmt_csr_master.sv]
// Master end: turns software commands into management accesses
`timescale 1ns/10ps
module mgmt_csr_master (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  mgmt_if.master bus
);
  import mgmt_csr_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b11,
    ST_DATA = 2'b10
  } mst_state_t;

  mst_state_t state_q;
  logic [15:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic done_q;
  logic wr_cmd;
  logic rd_cmd;

  assign wr_cmd = sw_wr_i && sw_addr_i == CTL_CMD && sw_wdata_i[CMD_WR_BIT];
  assign rd_cmd = sw_wr_i && sw_addr_i == CTL_CMD && sw_wdata_i[CMD_RD_BIT];

  // Legacy reset permanently low
  assign bus.legacy_rst = 1'b0;

  // Software-held address and data
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      addr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
    end
    else if (sw_wr_i && state_q == ST_IDLE)
    begin
      if (sw_addr_i == CTL_ADDR)
        addr_q <= sw_wdata_i[15:0];
      else if (sw_addr_i == CTL_WDATA)
        wdata_q <= sw_wdata_i;
    end
  end

  // Transfer sequencer; commands while busy are ignored
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
      rdata_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (wr_cmd)
          begin
            state_q <= ST_WRITE;
            done_q <= 1'b0;
          end
          else if (rd_cmd)
          begin
            state_q <= ST_READ;
            done_q <= 1'b0;
          end
        end
        // Writes never stall; one cycle ends them
        ST_WRITE:
        begin
          state_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        // Hold read until wait drops
        ST_READ:
          if (!bus.waitrequest)
            state_q <= ST_DATA;
        // Capture only with the valid strobe
        ST_DATA:
          if (bus.readdata_valid)
          begin
            rdata_q <= bus.readdata;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Bus strobes come straight from state
  always_comb
  begin
    bus.addr = addr_q;
    bus.writedata = wdata_q;
    bus.write = state_q == ST_WRITE;
    bus.read = state_q == ST_READ;
  end

  // Software read port, data one cycle after strobe
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sw_rdata_o <= 32'h0000_0000;
    else if (sw_rd_i)
    begin
      case (sw_addr_i)
        CTL_ADDR: sw_rdata_o <= {16'h0000, addr_q};
        CTL_WDATA: sw_rdata_o <= wdata_q;
        CTL_RDATA: sw_rdata_o <= rdata_q;
        CTL_STATUS: sw_rdata_o <= {30'h0, done_q, state_q != ST_IDLE};
        default: sw_rdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : mgmt_csr_master

// [mgmt_bus_chk.sv]
// Concurrent checks on the management port between the two ends
`timescale 1ns/10ps
module mgmt_bus_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] addr,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic readdata_valid,
  input wire logic waitrequest,
  input wire logic legacy_rst
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // A read step the device has stopped stalling
  sequence rd_served;
    read && !waitrequest;
  endsequence
  // Start of a fresh read request
  sequence rd_start;
    $rose(read);
  endsequence

  valid_after_read_a: assert property (rd_served |=> readdata_valid)
    else $error("read taken without data valid next cycle");
  valid_pulse_a: assert property (readdata_valid |=> !readdata_valid)
    else $error("data valid longer than one cycle");
  valid_cause_a: assert property (
    readdata_valid |-> $past(read) && !$past(waitrequest))
    else $error("data valid without a served read");
  write_no_wait_a: assert property (write |-> !waitrequest)
    else $error("write stalled by wait");
  read_held_a: assert property (
    read && waitrequest |=> read && $stable(addr))
    else $error("stalled read dropped or moved");
  legacy_tied_a: assert property (!legacy_rst)
    else $error("legacy reset not held low");
  one_strobe_a: assert property (!(read && write))
    else $error("read and write together");
  // Address and data are loaded before the command, so they sit still
  write_steady_a: assert property (
    write |-> $stable(writedata) && $stable(addr))
    else $error("write address or data moved with the strobe");
  read_bounded_a: assert property (
    rd_start |-> ##[2:40] readdata_valid)
    else $error("read never answered");
endmodule : mgmt_bus_chk

// [tb_top.sv]
// Self-checking bench driving the master's software port
`timescale 1ns/10ps
module tb_top;
  import mgmt_csr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tx_rst_n_i = 1'b1;
  logic rx_rst_n_i = 1'b1;
  logic csr_rst_n_i = 1'b1;
  logic [1:0] lane_tx_stable_i = 2'h0;
  logic [1:0] lane_block_lock_i = 2'h0;
  logic [1:0] lane_marker_found_i = 2'h0;
  logic [1:0] lane_deskewed_i = 2'h0;
  logic mac_local_fault_i = 1'b0;
  logic mac_remote_fault_i = 1'b0;
  logic tx_lanes_stable_o, rx_block_lock_o, receive_marker_found_o;
  logic rx_pcs_ready_o, local_fault_o, remote_fault_o;
  logic [31:0] setup_ctrl_o;
  logic [3:0] sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [31:0] sw_rdata_o;
  logic [5:0] stat;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  mgmt_if bus_if ();
  mgmt_csr_device mgmt_csr_device_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .tx_rst_n_i(tx_rst_n_i),
    .rx_rst_n_i(rx_rst_n_i), .csr_rst_n_i(csr_rst_n_i), .bus(bus_if),
    .lane_tx_stable_i(lane_tx_stable_i),
    .lane_block_lock_i(lane_block_lock_i),
    .lane_marker_found_i(lane_marker_found_i),
    .lane_deskewed_i(lane_deskewed_i),
    .mac_local_fault_i(mac_local_fault_i),
    .mac_remote_fault_i(mac_remote_fault_i),
    .tx_lanes_stable_o(tx_lanes_stable_o),
    .rx_block_lock_o(rx_block_lock_o),
    .receive_marker_found_o(receive_marker_found_o),
    .rx_pcs_ready_o(rx_pcs_ready_o), .local_fault_o(local_fault_o),
    .remote_fault_o(remote_fault_o), .setup_ctrl_o(setup_ctrl_o));
  mgmt_csr_master mgmt_csr_master_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
    .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .bus(bus_if));
  mgmt_bus_chk mgmt_bus_chk_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .addr(bus_if.addr), .read(bus_if.read),
    .write(bus_if.write), .writedata(bus_if.writedata),
    .readdata(bus_if.readdata), .readdata_valid(bus_if.readdata_valid),
    .waitrequest(bus_if.waitrequest), .legacy_rst(bus_if.legacy_rst));

  // Status outputs packed for one compare
  assign stat = {tx_lanes_stable_o, rx_block_lock_o, receive_marker_found_o,
                 rx_pcs_ready_o, local_fault_o, remote_fault_o};

  // 20 MHz clock shared by both ends and the checker
  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Hang guard; the full run needs well under this many cycles
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One strobe on the software port; read data stand the next cycle
  task automatic sw_acc(input logic wr, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= wr;
    sw_rd_i <= !wr;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
    sw_rd_i <= 1'b0;
    #1 q = sw_rdata_o;
  endtask : sw_acc

  // Full management access through the master, polling busy with a limit
  task automatic bus_acc(input logic wr, input logic [15:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    logic [31:0] s;
    int n;
    sw_acc(1'b1, CTL_ADDR, {16'h0000, a}, s);
    if (wr)
      sw_acc(1'b1, CTL_WDATA, d, s);
    sw_acc(1'b1, CTL_CMD, 32'h0000_0001 << (wr ? CMD_WR_BIT : CMD_RD_BIT), s);
    n = 0;
    do
    begin
      sw_acc(1'b0, CTL_STATUS, 32'h0000_0000, s);
      n++;
    end
    while (s[STS_BUSY_BIT] !== 1'b0 && n < 60);
    if (s[STS_BUSY_BIT] !== 1'b0)
      check(s, 32'h0000_0000);
    sw_acc(1'b0, CTL_RDATA, 32'h0000_0000, q);
  endtask : bus_acc

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_acc(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_acc(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rdc

  // Lane bits: [1:0] stable, [3:2] lock, [5:4] marker, [7:6] deskew
  task automatic drive_st(input logic [7:0] l, input logic [1:0] f);
    @(posedge ref_clk_i);
    lane_tx_stable_i <= l[1:0];
    lane_block_lock_i <= l[3:2];
    lane_marker_found_i <= l[5:4];
    lane_deskewed_i <= l[7:6];
    {mac_local_fault_i, mac_remote_fault_i} <= f;
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask : drive_st

  logic [5:0] one_low [4] = '{6'h1C, 6'h28, 6'h30, 6'h38};
  logic [15:0] spare [6] = '{16'h0400, 16'h04FF, 16'h0500, 16'h05FF,
                             16'h02FF, 16'h0600};

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    // Identity and scratch, link down throughout
    rdc(OFS_SCRATCH, SCRATCH_RST);
    rdc(OFS_REVISION, REVISION_VAL);
    rdc(OFS_NAME0, NAME0_VAL);
    rdc(OFS_NAME1, NAME1_VAL);
    rdc(OFS_NAME2, NAME2_VAL);
    wr(OFS_REVISION, 32'hFFFF_FFFF);
    rdc(OFS_REVISION, REVISION_VAL);
    wr(OFS_SCRATCH, 32'hA5A5_5A5A);
    rdc(OFS_SCRATCH, 32'hA5A5_5A5A);
    wr(OFS_SETUP, 32'hFFFF_FFFF);
    check(setup_ctrl_o, SETUP_MASK);
    $display("test registers done");
    // Other regions and gaps read back as empty; unused space is
    // defined as zero in this block, so these probes are safe
    foreach (spare[i])
    begin
      wr(spare[i], 32'h1234_5678);
      rdc(spare[i], UNMAPPED_DATA);
    end
    $display("test regions done");
    // Each lane condition missing on one lane holds its output low
    drive_st(8'hFF, 2'h0);
    check({26'h0, stat}, {26'h0, 6'h3C});
    for (int i = 0; i < 4; i++)
    begin
      drive_st(8'hFF & ~(8'h01 << (2 * i)), 2'h0);
      check({26'h0, stat}, {26'h0, one_low[i]});
    end
    drive_st(8'hFF, 2'h2);
    check({26'h0, stat}, {26'h0, 6'h3E});
    drive_st(8'hFF, 2'h1);
    check({26'h0, stat}, {26'h0, 6'h3D});
    $display("test status done");
    // Path resets leave the register bank alone and the port alive
    drive_st(8'hFF, 2'h0);
    wr(OFS_SCRATCH, 32'h1234_ABCD);
    for (int r = 0; r < 2; r++)
    begin
      @(posedge ref_clk_i);
      tx_rst_n_i <= (r != 0);
      rx_rst_n_i <= (r == 0);
      repeat (10) @(posedge ref_clk_i);
      #1 check({26'h0, stat}, {26'h0, (r == 0) ? 6'h1C : 6'h20});
      rdc(OFS_SCRATCH, 32'h1234_ABCD);
      // Release on an edge, not in the middle of a cycle
      @(posedge ref_clk_i);
      tx_rst_n_i <= 1'b1;
      rx_rst_n_i <= 1'b1;
      drive_st(8'hFF, 2'h0);
      check({26'h0, stat}, {26'h0, 6'h3C});
    end
    $display("test path resets done");
    // Global reset clears registers and silences the port
    @(posedge ref_clk_i);
    csr_rst_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    #1 check({26'h0, stat}, 32'h0000_0000);
    check({31'h0, bus_if.waitrequest}, 32'h0000_0001);
    @(posedge ref_clk_i);
    csr_rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rdc(OFS_SCRATCH, SCRATCH_RST);
    check(setup_ctrl_o, SETUP_RST);
    $display("test global reset done");
    give_verdict();
  end
endmodule : tb_top
